//--- rtl/acs_pkg.sv
package acs_pkg;

  // cpu clock periods in one machine cycle of the accelerated core
  localparam int unsigned MC_CPU_CLOCKS       = 6;
  // conversion length on the cpu clock, in machine cycles
  localparam int unsigned CONV_MACHINE_CYCLES = 31;
  // the same length in cpu clocks: 186 clocks, so 186 us divided by the rate in MHz
  localparam int unsigned CONV_CPU_CLOCKS     = CONV_MACHINE_CYCLES * MC_CPU_CLOCKS;
  // synchronisation before an rc-clocked conversion, in machine cycles
  localparam int unsigned SYNC_MC_MIN         = 3;
  localparam int unsigned SYNC_MC_MAX         = 4;
  // rc oscillator clocks of an rc-clocked conversion, and the documented upper bound
  localparam int unsigned RC_CONV_CLOCKS      = 108;
  localparam int unsigned RC_CONV_CLOCKS_MAX  = 112;

  // converter control fields and their values after reset
  localparam int unsigned CTRL_CHANNEL_LSB    = 0;
  localparam int unsigned CTRL_RC_SELECT_BIT  = 2;
  localparam logic [1:0]  CHANNEL_RESET       = 2'h0;
  localparam logic        RC_SELECT_RESET     = 1'h0;
  localparam logic [7:0]  RESULT_RESET        = 8'h00;

  // width of the shared countdown
  localparam int unsigned TIMER_WIDTH         = 8;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_CPU_CONV,
    ACS_RC_SYNC,
    ACS_RC_CONV
  } acs_state_e;

endpackage

//--- rtl/acs_sequencer.sv
// Notes on behaviour
// (R1) on the cpu clock a conversion takes exactly 31 machine cycles
// (R2) cpu-clocked conversion lasts 186 cpu clocks, i.e. 186 us over MHz
// (R3) rc clock select moves the converter onto the rc oscillator ticks
// (R4) rc conversion: 3 to 4 machine cycles of sync, then rc clocks
// (R5) software keeps rc select off when the cpu clock exceeds 4 MHz
// (R6) software keeps the cpu clock at or above 1 MHz for cpu-clocked use
// (R7) in idle, completion with interrupt enabled wakes the cpu
// (R8) power down with rc select keeps the conversion running
// (R9) power down on the cpu clock aborts, no wakeup, result marked invalid
// (R10) software enters idle or power down within two machine cycles of start
// (R11) software keeps other interrupts from waking the cpu mid conversion
// (R12) writing start begins conversion on the currently selected channel
// (R13) completion sets the done flag, used for polling or interrupt
// (R14) software clears the done flag after reading before the next start
// (R15) software ors channel into low bits and masks them off afterwards
// (R16) result is readable once the done flag is set
// (R17) software enables the interrupt before setting start
// (R18) start reads busy during conversion; further starts are ignored
// (R19) rc completion in power down sets done and wakes if enabled
`timescale 1ns/1ns
`default_nettype none

module acs_sequencer #(
  parameter int unsigned RESULT_WIDTH = 8
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst_n,
  // one pulse per cpu oscillator clock, and one per rc oscillator clock
  input  wire logic                    i_cpu_tick,
  input  wire logic                    i_rc_tick,
  // cpu power state and converter interrupt enable
  input  wire logic                    i_idle,
  input  wire logic                    i_power_down,
  input  wire logic                    i_interrupt_enable,
  // software writes to the converter control register
  input  wire logic                    i_control_write,
  input  wire logic [2:0]              i_control_data,
  input  wire logic                    i_start_write,
  input  wire logic                    i_done_clear,
  // sample from the analog core, valid when the conversion ends
  input  wire logic [RESULT_WIDTH-1:0] i_core_data,
  output logic                         o_conversion_start_busy,
  output logic                         o_conversion_done_flag,
  output logic [RESULT_WIDTH-1:0]      o_conversion_result,
  output logic                         o_result_valid,
  output logic [1:0]                   o_channel_select,
  output logic                         o_rc_clock_select,
  output logic                         o_interrupt_request,
  output logic                         o_wakeup
);

  initial begin
    if (RESULT_WIDTH < 1 || RESULT_WIDTH > 16) begin
      $error("acs_sequencer: RESULT_WIDTH must be 1 to 16");
    end
  end

  localparam int unsigned TW = acs_pkg::TIMER_WIDTH;
  localparam logic [TW-1:0] CPU_LOAD  = TW'(acs_pkg::CONV_CPU_CLOCKS);
  localparam logic [TW-1:0] SYNC_LOAD = TW'(acs_pkg::SYNC_MC_MAX);
  localparam logic [TW-1:0] RC_LOAD   = TW'(acs_pkg::RC_CONV_CLOCKS);
  localparam logic [2:0]    MC_LAST   = 3'(acs_pkg::MC_CPU_CLOCKS - 1);

  acs_timer_if #(.WIDTH(TW)) tif ();

  acs_timer #(
    .WIDTH (TW)
  ) u_timer (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .tif     (tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle divider

  logic [2:0] mc_phase;
  logic [2:0] next_mc_phase;
  logic       mc_pulse;
  logic       next_mc_pulse;

  // free running so a start lands anywhere inside a machine cycle
  always_comb begin
    next_mc_phase = mc_phase;
    next_mc_pulse = 1'b0;
    if (i_cpu_tick) begin
      next_mc_pulse = (mc_phase == MC_LAST);
      next_mc_phase = (mc_phase == MC_LAST) ? 3'h0 : mc_phase + 3'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mc_phase <= 3'h0;
      mc_pulse <= 1'b0;
    end else begin
      mc_phase <= next_mc_phase;
      mc_pulse <= next_mc_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequence and software visible state

  acs_pkg::acs_state_e          state;
  acs_pkg::acs_state_e          next_state;
  logic                         busy;
  logic                         next_busy;
  logic                         done;
  logic                         next_done;
  logic [RESULT_WIDTH-1:0]      result;
  logic [RESULT_WIDTH-1:0]      next_result;
  logic                         valid;
  logic                         next_valid;
  logic [1:0]                   channel;
  logic [1:0]                   next_channel;
  logic                         rc_sel;
  logic                         next_rc_sel;
  logic                         irq;
  logic                         next_irq;
  logic                         wake;
  logic                         next_wake;
  logic                         finish;

  // the converter can only start with both busy and done clear
  function automatic logic can_start(input logic b, input logic d);
    return !b && !d;
  endfunction

  always_comb begin
    next_state     = state;
    next_busy      = busy;
    next_done      = done;
    next_result    = result;
    next_valid     = valid;
    next_channel   = channel;
    next_rc_sel    = rc_sel;
    next_wake      = 1'b0;
    finish         = 1'b0;
    tif.load       = 1'b0;
    tif.load_value = CPU_LOAD;
    tif.tick       = 1'b0;

    // channel and clock source only change while the converter is quiet
    if (i_control_write && can_start(busy, done)) begin
      next_channel = i_control_data[acs_pkg::CTRL_CHANNEL_LSB +: 2];
      next_rc_sel  = i_control_data[acs_pkg::CTRL_RC_SELECT_BIT]; // [R3]
    end
    // software clear first, so a completion below in the same cycle wins
    if (i_done_clear) begin
      next_done = 1'b0;
    end

    unique case (state)
      acs_pkg::ACS_IDLE: begin
        // starts while busy or done are simply dropped
        if (i_start_write && can_start(busy, done)) begin // [R18]
          next_busy  = 1'b1;
          next_valid = 1'b0;
          tif.load   = 1'b1;
          if (rc_sel) begin // [R3]
            tif.load_value = SYNC_LOAD;
            next_state     = acs_pkg::ACS_RC_SYNC;
          end else begin
            tif.load_value = CPU_LOAD; // [R1] [R2]
            next_state     = acs_pkg::ACS_CPU_CONV;
          end
        end
      end
      acs_pkg::ACS_CPU_CONV: begin
        tif.tick = i_cpu_tick; // [R2]
        if (i_power_down) begin
          // oscillator stops: abort quietly, result left invalid
          next_busy  = 1'b0; // [R9]
          next_valid = 1'b0; // [R9]
          next_state = acs_pkg::ACS_IDLE;
        end else if (tif.expired) begin
          finish = 1'b1; // [R1]
        end
      end
      acs_pkg::ACS_RC_SYNC: begin
        // the first machine cycle is partial, so 4 pulses span 3 to 4 cycles
        tif.tick = mc_pulse; // [R4]
        if (tif.expired || i_power_down) begin
          tif.load       = 1'b1;
          tif.load_value = RC_LOAD; // [R4]
          next_state     = acs_pkg::ACS_RC_CONV;
        end
      end
      acs_pkg::ACS_RC_CONV: begin
        // rc ticks keep running with the cpu clock stopped
        tif.tick = i_rc_tick; // [R8] [R4]
        if (tif.expired) begin
          finish = 1'b1; // [R8]
        end
      end
    endcase

    if (finish) begin
      next_state  = acs_pkg::ACS_IDLE;
      next_busy   = 1'b0;
      next_done   = 1'b1; // [R13] [R19]
      next_result = i_core_data; // [R16]
      next_valid  = 1'b1; // [R16]
      // leave idle or power down only when the interrupt is enabled
      next_wake   = i_interrupt_enable && (i_idle || i_power_down); // [R7] [R19]
    end

    next_irq = next_done && i_interrupt_enable; // [R13]
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state   <= acs_pkg::ACS_IDLE;
      busy    <= 1'b0;
      done    <= 1'b0;
      result  <= RESULT_WIDTH'(acs_pkg::RESULT_RESET);
      valid   <= 1'b0;
      channel <= acs_pkg::CHANNEL_RESET;
      rc_sel  <= acs_pkg::RC_SELECT_RESET;
      irq     <= 1'b0;
      wake    <= 1'b0;
    end else begin
      state   <= next_state;
      busy    <= next_busy;
      done    <= next_done;
      result  <= next_result;
      valid   <= next_valid;
      channel <= next_channel;
      rc_sel  <= next_rc_sel;
      irq     <= next_irq;
      wake    <= next_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign o_conversion_start_busy = busy; // [R18]
  assign o_conversion_done_flag  = done; // [R13]
  assign o_conversion_result     = result; // [R16]
  assign o_result_valid          = valid;
  assign o_channel_select        = channel; // [R12]
  assign o_rc_clock_select       = rc_sel;
  assign o_interrupt_request     = irq;
  assign o_wakeup                = wake;

endmodule

`default_nettype wire

//--- rtl/acs_timer.sv
`timescale 1ns/1ns
`default_nettype none

// loadable countdown: expired pulses for one cycle when the last tick lands
module acs_timer #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic  i_clock,
  input  wire logic  i_rst_n,
  acs_timer_if.timer tif
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             expired;
  logic             next_expired;

  initial begin
    if (WIDTH < 8) begin
      $error("acs_timer: WIDTH too small for the longest conversion count");
    end
  end

  // a load overrides a tick in the same cycle so a fresh count never loses a step
  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (tif.load) begin
      next_count = tif.load_value;
    end else if (tif.tick && count != '0) begin
      next_count   = count - 1'b1;
      next_expired = (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

  assign tif.expired = expired;

endmodule

`default_nettype wire

//--- rtl/acs_timer_if.sv
`timescale 1ns/1ns
`default_nettype none

// countdown request from the sequencer and expiry answer from the timer
interface acs_timer_if #(
  parameter int unsigned WIDTH = 8
);
  logic             load;
  logic [WIDTH-1:0] load_value;
  logic             tick;
  logic             expired;

  modport ctrl  (output load, output load_value, output tick, input  expired);
  modport timer (input  load, input  load_value, input  tick, output expired);
endinterface

`default_nettype wire

//--- verif/acs_sequencer_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module acs_sequencer_checker (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_cpu_tick,
  input wire logic       i_idle,
  input wire logic       i_power_down,
  input wire logic       i_interrupt_enable,
  input wire logic       i_control_write,
  input wire logic [2:0] i_control_data,
  input wire logic       i_start_write,
  input wire logic       i_done_clear,
  input wire logic       o_conversion_start_busy,
  input wire logic       o_conversion_done_flag,
  input wire logic       o_result_valid,
  input wire logic [1:0] o_channel_select,
  input wire logic       o_rc_clock_select,
  input wire logic       o_interrupt_request,
  input wire logic       o_wakeup
);
  // short names keep the properties readable
  wire busy = o_conversion_start_busy;
  wire done = o_conversion_done_flag;
  wire rc   = o_rc_clock_select;
  wire take = i_start_write && !busy && !done;
  wire cwr  = i_control_write && !busy && !done;

  ////////////////////////////////////////////////////////////
  // cpu ticks seen while busy; cleared on an accepted start
  logic [8:0] tick_cnt;
  logic [8:0] next_tick_cnt;
  always_comb begin
    next_tick_cnt = tick_cnt;
    if (take) begin
      next_tick_cnt = 9'h000;
    end else if (busy && i_cpu_tick) begin
      next_tick_cnt = tick_cnt + 9'h001;
    end
  end
  // registers only; the count is only trusted when rc select is low
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt <= 9'h000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_start;
    take && !i_power_down |=> busy && !o_result_valid;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_len;
    $rose(done) && !rc |-> $past(tick_cnt) == 9'(acs_pkg::CONV_CPU_CLOCKS);
  endproperty
  a_len: assert property (p_len) else $error("conversion length off");
  property p_ctrl;
    cwr |=> o_channel_select == $past(i_control_data[1:0]) && rc == $past(i_control_data[2]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write lost");
  property p_hold;
    busy || done |=> $stable(o_channel_select) && $stable(rc);
  endproperty
  a_hold: assert property (p_hold) else $error("control changed while busy");
  property p_sticky;
    done && !i_done_clear |=> done;
  endproperty
  a_sticky: assert property (p_sticky) else $error("done flag dropped");
  property p_irq;
    o_interrupt_request == (done && $past(i_interrupt_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong");
  property p_wake;
    $rose(done) && $past(i_interrupt_enable && (i_idle || i_power_down)) |-> o_wakeup;
  endproperty
  a_wake: assert property (p_wake) else $error("no wakeup at completion");
  property p_abort;
    busy && i_power_down && !rc |=> !busy && !done && !o_result_valid && !o_wakeup;
  endproperty
  a_abort: assert property (p_abort) else $error("power down did not abort");
  property p_rc_pd;
    busy && rc && i_power_down |=> busy || done;
  endproperty
  a_rc_pd: assert property (p_rc_pd) else $error("rc conversion stopped");

  c_cpu_done: cover property ($rose(done) && !rc);
  c_abort: cover property (busy && i_power_down && !rc);
  c_rc_done: cover property ($rose(done) && rc && i_power_down);
endmodule

bind acs_sequencer acs_sequencer_checker u_acs_sequencer_checker (.i_clock, .i_rst_n,
  .i_cpu_tick, .i_idle, .i_power_down, .i_interrupt_enable, .i_control_write,
  .i_control_data, .i_start_write, .i_done_clear, .o_conversion_start_busy,
  .o_conversion_done_flag, .o_result_valid, .o_channel_select, .o_rc_clock_select,
  .o_interrupt_request, .o_wakeup);

`default_nettype wire

//--- verif/test_acs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module test_acs_sequencer;
  logic       i_clock, i_rst_n, i_cpu_tick, i_rc_tick, i_idle, i_power_down;
  logic       i_interrupt_enable, i_control_write, i_start_write, i_done_clear;
  logic [2:0] i_control_data;
  logic [7:0] i_core_data, o_conversion_result;
  logic       o_conversion_start_busy, o_conversion_done_flag, o_result_valid;
  logic [1:0] o_channel_select;
  logic       o_rc_clock_select, o_interrupt_request, o_wakeup;
  int         n_mismatch, compares, n;

  // rc conversion span in clock cycles with both tick inputs high every cycle
  localparam int RC_SPAN_MIN = acs_pkg::SYNC_MC_MIN * acs_pkg::MC_CPU_CLOCKS
                               + acs_pkg::RC_CONV_CLOCKS;
  localparam int RC_SPAN_MAX = acs_pkg::SYNC_MC_MAX * acs_pkg::MC_CPU_CLOCKS
                               + acs_pkg::RC_CONV_CLOCKS_MAX;

  acs_sequencer u_acs_sequencer (.i_clock, .i_rst_n, .i_cpu_tick, .i_rc_tick, .i_idle,
    .i_power_down, .i_interrupt_enable, .i_control_write, .i_control_data, .i_start_write,
    .i_done_clear, .i_core_data, .o_conversion_start_busy, .o_conversion_done_flag,
    .o_conversion_result, .o_result_valid, .o_channel_select, .o_rc_clock_select,
    .o_interrupt_request, .o_wakeup);

  // 125 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////
  // software strobes: raised at a falling edge, dropped at the next one
  task automatic ctrl(input logic [2:0] d);
    i_control_data = d;
    i_control_write = 1'b1;
    @(negedge i_clock) i_control_write = 1'b0;
  endtask
  task automatic start;
    i_start_write = 1'b1;
    @(negedge i_clock) i_start_write = 1'b0;
  endtask
  task automatic clear;
    i_done_clear = 1'b1;
    @(negedge i_clock) i_done_clear = 1'b0;
  endtask
  // bounded wait for the done flag; n counts falling edges passed
  task automatic wait_done(input int max);
    n = 0;
    while (o_conversion_done_flag !== 1'b1 && n < max) begin
      @(negedge i_clock) n++;
    end
    if (o_conversion_done_flag !== 1'b1) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {i_rst_n, i_cpu_tick, i_rc_tick, i_idle, i_power_down, i_interrupt_enable} = '0;
    {i_control_write, i_start_write, i_done_clear, i_control_data} = '0;
    i_core_data = 8'h5a;
    n_mismatch = 0;
    compares = 0;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock) i_rst_n = 1'b1;
    `CHK({o_conversion_start_busy, o_conversion_done_flag, o_wakeup}, 3'h0)
    // cpu clock, idle, interrupt on; writes while busy must bounce
    i_cpu_tick = 1'b1;
    i_interrupt_enable = 1'b1;
    ctrl(3'h2);
    `CHK(o_channel_select, 2'h2)
    i_idle = 1'b1;
    start;
    ctrl(3'h5);
    start;
    wait_done(300);
    // done lands CONV+2 cycles after start; three already spent above
    `CHK(n, acs_pkg::CONV_CPU_CLOCKS - 1)
    `CHK({o_wakeup, o_result_valid, o_conversion_result}, {2'h3, 8'h5a})
    `CHK(o_channel_select, 2'h2)
    @(negedge i_clock);
    `CHK({o_interrupt_request, o_wakeup}, 2'h2)
    start;
    `CHK(o_conversion_start_busy, 1'b0)
    clear;
    `CHK(o_conversion_done_flag, 1'b0)
    // software masks the channel bits off once the flag is clear
    ctrl(3'h0);
    `CHK(o_channel_select, 2'h0)
    $display("test cpu conversion done");
    // power down on the cpu clock throws the conversion away
    i_idle = 1'b0;
    start;
    repeat (20) @(negedge i_clock);
    i_power_down = 1'b1;
    i_cpu_tick = 1'b0;
    @(negedge i_clock);
    `CHK({o_conversion_start_busy, o_conversion_done_flag, o_result_valid}, 3'h0)
    repeat (200) @(negedge i_clock);
    `CHK({o_conversion_done_flag, o_wakeup}, 2'h0)
    i_power_down = 1'b0;
    i_cpu_tick = 1'b1;
    $display("test abort done");
    // rc clock with the cpu running: machine cycle sync, then rc clocks
    ctrl(3'h7);
    `CHK({o_rc_clock_select, o_channel_select}, 3'h7)
    i_core_data = 8'h3c;
    i_rc_tick = 1'b1;
    start;
    wait_done(300);
    `CHK(n >= RC_SPAN_MIN && n <= RC_SPAN_MAX, 1'b1)
    `CHK({o_wakeup, o_result_valid, o_conversion_result}, {2'h1, 8'h3c})
    clear;
    $display("test rc conversion with sync done");
    // rc clock, power down entered at once; the rc ticks carry it through
    i_core_data = 8'ha5;
    start;
    i_power_down = 1'b1;
    i_cpu_tick = 1'b0;
    wait_done(300);
    `CHK(n >= acs_pkg::RC_CONV_CLOCKS && n <= acs_pkg::RC_CONV_CLOCKS_MAX, 1'b1)
    `CHK({o_wakeup, o_conversion_result}, {1'b1, 8'ha5})
    i_power_down = 1'b0;
    clear;
    $display("test rc conversion done");
    end_sim;
  end
endmodule

`default_nettype wire
